/* File: include/pbd_cfg.svh */
// Purpose: register offsets, fields and reset values for the loop B control bank
// Assumes: byte-wide register port, 16-bit byte addresses
// Notes:   definitions only
`ifndef PBD_CFG_SVH
`define PBD_CFG_SVH

`define PBD_ADDR_BW_APPLY       16'h0514
`define PBD_ADDR_NUM_BASE       16'h0515
`define PBD_ADDR_NUM_LAST       16'h051B
`define PBD_ADDR_DEN_BASE       16'h051C
`define PBD_ADDR_DEN_LAST       16'h051F
`define PBD_ADDR_DIV_APPLY      16'h0520
`define PBD_ADDR_FRAC_CTRL      16'h0521
`define PBD_ADDR_INSEL_CTRL     16'h052A
`define PBD_ADDR_FAST_CTRL      16'h052B
`define PBD_ADDR_HOLD_CTRL      16'h052C

`define PBD_NUM_BYTES           7
`define PBD_DEN_BYTES           4
`define PBD_PRESCALE            4'h5

`define PBD_FRAC_MODE_LSB       0
`define PBD_FRAC_EN_BIT         4
`define PBD_FRAC_RSVD_BIT       5
`define PBD_INSEL_SRC_BIT       0
`define PBD_INSEL_LSB           1
`define PBD_FAST_AUTO_BIT       0
`define PBD_FAST_MAN_BIT        1
`define PBD_HOLD_EN_BIT         0
`define PBD_HOLD_BYP_BIT        3
`define PBD_HOLD_EXIT_BIT       4
`define PBD_HOLD_RATE_LSB       5

`define PBD_RST_FRAC_CTRL       8'h00
`define PBD_RST_INSEL_CTRL      8'h00
`define PBD_RST_FAST_CTRL       8'h00
`define PBD_RST_HOLD_CTRL       8'h01

`endif

/* File: include/pbd_pkg.sv */
// Purpose: shared types of the loop B control bank
// Assumes: nothing
// Notes:   rates in units of 0.01 ppm/s, multiplier in quarters
package pbd_pkg;

  typedef struct packed {
    logic [55:0] numerator;
    logic [31:0] denominator;
  } pbd_divider_t;

  typedef struct packed {
    logic       frac_enable;
    logic [3:0] frac_mode;
    logic [3:0] prescale;
  } pbd_div_mode_t;

  typedef struct packed {
    logic [1:0] active_input;
    logic       input_valid;
    logic       fast_bw_sel;
    logic       hold_allow;
    logic       exit_normal_bw;
    logic       ramp_bypass;
    logic [12:0] base_rate_cps;
    logic [12:0] step_mult_q;
  } pbd_loop_ctrl_t;

  typedef enum logic [1:0] {
    PBD_FL_IDLE  = 2'b00,
    PBD_FL_AUTO  = 2'b01,
    PBD_FL_FORCE = 2'b10
  } pbd_fast_state_t;

endpackage

/* File: rtl/pbd_byte_field.sv */
// Purpose: multi-byte little-endian field with staged and working copies
// Assumes: one byte written per cycle
// Notes:   transfer copies every staged byte at once
`timescale 1ns/1ps
`default_nettype none
module pbd_byte_field #(
  parameter int NBYTES = 4
) (
  // clock and control
  input  wire logic               mclk,
  input  wire logic               reset,
  input  wire logic               clk_en,
  // byte write
  input  wire logic               wr_en,
  input  wire logic [2:0]         wr_idx,
  input  wire logic [7:0]         wr_data,
  input  wire logic               transfer,
  // values
  output logic [NBYTES*8-1:0]     staged,
  output logic [NBYTES*8-1:0]     working
);
  logic [NBYTES*8-1:0] staged_reg;
  wire  [NBYTES*8-1:0] staged_next;
  logic [NBYTES*8-1:0] working_reg;
  logic [NBYTES*8-1:0] working_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    working_next = transfer ? staged_reg : working_reg;
  end

  // per byte write select
  genvar gi;
  generate
    for (gi = 0; gi < NBYTES; gi++) begin : g_byte
      assign staged_next[gi*8 +: 8] = (wr_en && wr_idx == 3'(gi)) ? wr_data
                                                                  : staged_reg[gi*8 +: 8];
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (reset) begin
      staged_reg  <= '0;
      working_reg <= '0;
    end else if (clk_en) begin
      staged_reg  <= staged_next;
      working_reg <= working_next;
    end
  end

  assign staged  = staged_reg;
  assign working = working_reg;
endmodule
`default_nettype wire

/* File: rtl/pbd_ramp_decode.sv */
// Purpose: decode ramp base rate and step multiplier codes
// Assumes: codes stable from registers
// Notes:   rate in 0.01 ppm/s, multiplier in quarters
`timescale 1ns/1ps
`default_nettype none
module pbd_ramp_decode (
  // codes
  input  wire logic [2:0]  rate_code,
  input  wire logic [2:0]  step_code,
  // decoded
  output logic [12:0]      rate_cps,
  output logic [12:0]      mult_q
);
  always_comb begin
    unique case (rate_code)
      3'h0: rate_cps = 13'h0094;
      3'h1: rate_cps = 13'h00DE;
      3'h2: rate_cps = 13'h00FD;
      3'h3: rate_cps = 13'h0076;
      3'h4: rate_cps = 13'h004A;
      3'h5: rate_cps = 13'h01FA;
      3'h6: rate_cps = 13'h03F4;
      3'h7: rate_cps = 13'h0FD0;
    endcase
  end

  always_comb begin
    unique case (step_code)
      3'h0: mult_q = 13'h0004;
      3'h1: mult_q = 13'h0010;
      3'h2: mult_q = 13'h0040;
      3'h3: mult_q = 13'h0100;
      3'h4: mult_q = 13'h0400;
      3'h5: mult_q = 13'h1000;
      3'h6: mult_q = 13'h0001;
      3'h7: mult_q = 13'h0002;
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/pbd_bank.sv */
// Purpose: register bank steering divider, input choice, fast settle and holdover of loop B
// Assumes: host byte port synchronous to mclk; pins synchronous
// Notes:   bandwidth parameter sets held outside, applied on bw_apply pulse
`timescale 1ns/1ps
`default_nettype none
`include "pbd_cfg.svh"

// Functional notes
// - bandwidth strobe write applies normal, fast and hold sets in one pulse, self clears
// - device soft reset applies bandwidth; single loop soft reset does not
// - numerator is 56 bits in seven bytes, lowest address holds low byte
// - denominator is 32 bits in four bytes, low byte at lowest address
// - fixed divide by five prescaler ahead of fractional divider
// - divider strobe or device soft reset copies staged ratio to working divider
// - fraction enable zero gives integer division, one allows fractional
// - select source bit zero uses pins, one uses register choice
// - register choice codes 0..3 pick inputs, 4..7 reserved
// - zero delay mode uses zero delay choice, source bit still applies
// - with source bit zero register choice has no effect
// - auto or forced fast settle selects quick settle bandwidth
// - auto only: return to normal bandwidth once lock is gained
// - hold enable one permits holdover, zero prevents it
// - exit bit zero exits holdover on fast bandwidth, one on normal
// - base ramp rate code maps to eight listed ppm/s values
// - step multiplier code maps to 1,4,16,64,256,1024,1/4,1/2
module pbd_bank
  import pbd_pkg::*;
(
  // clock and control
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         clk_en,
  // soft resets
  input  wire logic         device_soft_reset,
  input  wire logic         single_loop_soft_reset,
  // register port
  input  wire logic [15:0]  reg_addr,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [7:0]   reg_wdata,
  output logic [7:0]        reg_rdata,
  // pins and loop status
  input  wire logic [1:0]   select_pins,
  input  wire logic         zero_delay_mode,
  input  wire logic [1:0]   zero_delay_input_choice,
  input  wire logic         loss_of_lock_flag,
  // to loop core
  output logic              bandwidth_apply_strobe,
  output logic              divider_apply_strobe,
  output pbd_divider_t      divider_working,
  output pbd_div_mode_t     divider_mode,
  output pbd_loop_ctrl_t    loop_ctrl
);
  logic [55:0] num_staged;
  logic [55:0] num_working;
  logic [31:0] den_staged;
  logic [31:0] den_working;
  logic [7:0]  frac_reg;
  logic [7:0]  frac_next;
  logic [7:0]  insel_reg;
  logic [7:0]  insel_next;
  logic [7:0]  fast_reg;
  logic [7:0]  fast_next;
  logic [7:0]  hold_reg;
  logic [7:0]  hold_next;
  logic        bw_pulse_reg;
  logic        bw_pulse_next;
  logic        div_pulse_reg;
  logic        div_pulse_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        wr_num;
  logic        wr_den;
  logic [2:0]  num_idx;
  logic [2:0]  den_idx;
  logic        div_transfer;
  logic [12:0] rate_cps;
  logic [12:0] mult_q;
  logic [1:0]  choice;
  logic        choice_ok;
  pbd_fast_state_t fl_reg;
  pbd_fast_state_t fl_next;

  ////////////////////////////////////////////////////////////////////////////
  assign wr_num  = reg_wr && reg_addr >= `PBD_ADDR_NUM_BASE && reg_addr <= `PBD_ADDR_NUM_LAST;
  assign wr_den  = reg_wr && reg_addr >= `PBD_ADDR_DEN_BASE && reg_addr <= `PBD_ADDR_DEN_LAST;
  assign num_idx = 3'(reg_addr - `PBD_ADDR_NUM_BASE);
  assign den_idx = 3'(reg_addr - `PBD_ADDR_DEN_BASE);
  assign div_transfer = div_pulse_reg;

  pbd_byte_field #(.NBYTES(`PBD_NUM_BYTES)) u_num (
    .mclk     (mclk),
    .reset    (reset),
    .clk_en   (clk_en),
    .wr_en    (wr_num),
    .wr_idx   (num_idx),
    .wr_data  (reg_wdata),
    .transfer (div_transfer),
    .staged   (num_staged),
    .working  (num_working)
  );

  pbd_byte_field #(.NBYTES(`PBD_DEN_BYTES)) u_den (
    .mclk     (mclk),
    .reset    (reset),
    .clk_en   (clk_en),
    .wr_en    (wr_den),
    .wr_idx   (den_idx),
    .wr_data  (reg_wdata),
    .transfer (div_transfer),
    .staged   (den_staged),
    .working  (den_working)
  );

  pbd_ramp_decode u_ramp (
    .rate_code (hold_reg[7:5]),
    .step_code (fast_reg[4:2]),
    .rate_cps  (rate_cps),
    .mult_q    (mult_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register writes and strobes
  always_comb begin
    frac_next  = frac_reg;
    insel_next = insel_reg;
    fast_next  = fast_reg;
    hold_next  = hold_reg;
    bw_pulse_next  = device_soft_reset;
    div_pulse_next = device_soft_reset;
    if (reg_wr) begin
      unique case (reg_addr)
        `PBD_ADDR_BW_APPLY:   bw_pulse_next  = bw_pulse_next | reg_wdata[0];
        `PBD_ADDR_DIV_APPLY:  div_pulse_next = div_pulse_next | reg_wdata[0];
        `PBD_ADDR_FRAC_CTRL:  frac_next  = {2'h0, reg_wdata[5:0]};
        `PBD_ADDR_INSEL_CTRL: insel_next = {4'h0, reg_wdata[3:0]};
        `PBD_ADDR_FAST_CTRL:  fast_next  = {3'h0, reg_wdata[4:0]};
        `PBD_ADDR_HOLD_CTRL:  hold_next  = {reg_wdata[7:3], 2'h0, reg_wdata[0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      frac_reg      <= `PBD_RST_FRAC_CTRL;
      insel_reg     <= `PBD_RST_INSEL_CTRL;
      fast_reg      <= `PBD_RST_FAST_CTRL;
      hold_reg      <= `PBD_RST_HOLD_CTRL;
      bw_pulse_reg  <= 1'b0;
      div_pulse_reg <= 1'b0;
    end else if (clk_en) begin
      frac_reg      <= frac_next;
      insel_reg     <= insel_next;
      fast_reg      <= fast_next;
      hold_reg      <= hold_next;
      bw_pulse_reg  <= bw_pulse_next;
      div_pulse_reg <= div_pulse_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      rdata_next = 8'h00;
      if (reg_addr >= `PBD_ADDR_NUM_BASE && reg_addr <= `PBD_ADDR_NUM_LAST) begin
        rdata_next = num_staged[num_idx*8 +: 8];
      end else if (reg_addr >= `PBD_ADDR_DEN_BASE && reg_addr <= `PBD_ADDR_DEN_LAST) begin
        rdata_next = den_staged[den_idx[1:0]*8 +: 8];
      end else if (reg_addr == `PBD_ADDR_FRAC_CTRL) begin
        rdata_next = frac_reg;
      end else if (reg_addr == `PBD_ADDR_INSEL_CTRL) begin
        rdata_next = insel_reg;
      end else if (reg_addr == `PBD_ADDR_FAST_CTRL) begin
        rdata_next = {3'h0, fast_reg[4:2], fast_reg[1:0]};
      end else if (reg_addr == `PBD_ADDR_HOLD_CTRL) begin
        rdata_next = hold_reg;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fast settle state
  always_comb begin
    fl_next = fl_reg;
    unique case (fl_reg)
      PBD_FL_IDLE: begin
        if (fast_reg[`PBD_FAST_MAN_BIT]) begin
          fl_next = PBD_FL_FORCE;
        end else if (fast_reg[`PBD_FAST_AUTO_BIT] && loss_of_lock_flag) begin
          fl_next = PBD_FL_AUTO;
        end
      end
      PBD_FL_AUTO: begin
        if (fast_reg[`PBD_FAST_MAN_BIT]) begin
          fl_next = PBD_FL_FORCE;
        end else if (!fast_reg[`PBD_FAST_AUTO_BIT] || !loss_of_lock_flag) begin
          fl_next = PBD_FL_IDLE;
        end
      end
      PBD_FL_FORCE: begin
        if (!fast_reg[`PBD_FAST_MAN_BIT]) begin
          fl_next = PBD_FL_IDLE;
        end
      end
      default: fl_next = PBD_FL_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      fl_reg <= PBD_FL_IDLE;
    end else if (clk_en) begin
      fl_reg <= fl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    if (!insel_reg[`PBD_INSEL_SRC_BIT]) begin
      choice    = select_pins;
      choice_ok = 1'b1;
    end else if (zero_delay_mode) begin
      choice    = zero_delay_input_choice;
      choice_ok = 1'b1;
    end else begin
      choice    = insel_reg[2:1];
      choice_ok = !insel_reg[3];
    end
  end

  assign bandwidth_apply_strobe = bw_pulse_reg;
  assign divider_apply_strobe   = div_pulse_reg;
  assign divider_working.numerator   = num_working;
  assign divider_working.denominator = den_working;
  assign divider_mode.frac_enable = frac_reg[`PBD_FRAC_EN_BIT];
  assign divider_mode.frac_mode   = frac_reg[3:0];
  assign divider_mode.prescale    = `PBD_PRESCALE;
  assign loop_ctrl.active_input   = choice;
  assign loop_ctrl.input_valid    = choice_ok;
  assign loop_ctrl.fast_bw_sel    = (fl_reg != PBD_FL_IDLE);
  assign loop_ctrl.hold_allow     = hold_reg[`PBD_HOLD_EN_BIT];
  assign loop_ctrl.exit_normal_bw = hold_reg[`PBD_HOLD_EXIT_BIT];
  assign loop_ctrl.ramp_bypass    = hold_reg[`PBD_HOLD_BYP_BIT];
  assign loop_ctrl.base_rate_cps  = rate_cps;
  assign loop_ctrl.step_mult_q    = mult_q;
  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_bw_write;
    reg_wr && clk_en && reg_addr == `PBD_ADDR_BW_APPLY && reg_wdata[0];
  endsequence

  AST_BW_PULSE: assert property (@(posedge mclk) disable iff (reset)
    s_bw_write |=> bandwidth_apply_strobe)
    else $error("bandwidth apply missing");
  AST_BW_SELF_CLEAR: assert property (@(posedge mclk) disable iff (reset)
    (bandwidth_apply_strobe && clk_en && !reg_wr && !device_soft_reset)
      |=> !bandwidth_apply_strobe)
    else $error("bandwidth strobe stuck");
  AST_SOFT_RST_BW: assert property (@(posedge mclk) disable iff (reset)
    (clk_en && device_soft_reset) |=> bandwidth_apply_strobe && divider_apply_strobe)
    else $error("soft reset did not apply");
  AST_LOOP_RST_NO_BW: assert property (@(posedge mclk) disable iff (reset)
    (clk_en && single_loop_soft_reset && !device_soft_reset && !reg_wr)
      |=> !bandwidth_apply_strobe)
    else $error("loop reset applied bandwidth");
  AST_DIV_COPY: assert property (@(posedge mclk) disable iff (reset)
    (divider_apply_strobe && clk_en && !wr_num)
      |=> divider_working.numerator == $past(num_staged))
    else $error("divider not copied");
  AST_PIN_SELECT: assert property (@(posedge mclk) disable iff (reset)
    !insel_reg[0] |-> loop_ctrl.active_input == select_pins)
    else $error("pins not followed");
  AST_ZDM_SELECT: assert property (@(posedge mclk) disable iff (reset)
    (insel_reg[0] && zero_delay_mode) |-> loop_ctrl.active_input == zero_delay_input_choice)
    else $error("zero delay choice ignored");
  AST_FORCE_FAST: assert property (@(posedge mclk) disable iff (reset)
    (clk_en && fast_reg[1])[*2] |=> loop_ctrl.fast_bw_sel)
    else $error("forced fast settle not used");
  AST_AUTO_RETURN: assert property (@(posedge mclk) disable iff (reset)
    (clk_en && fl_reg == PBD_FL_AUTO && !fast_reg[1] && !loss_of_lock_flag)
      |=> !loop_ctrl.fast_bw_sel)
    else $error("auto fast settle did not return");
  AST_PRESCALE: assert property (@(posedge mclk) disable iff (reset)
    divider_mode.prescale == 4'h5)
    else $error("prescale wrong");
  AST_FRAC_EN_WRITE: assert property (@(posedge mclk) disable iff (reset)
    (clk_en && reg_wr && reg_addr == `PBD_ADDR_FRAC_CTRL)
      |=> divider_mode.frac_enable == $past(reg_wdata[`PBD_FRAC_EN_BIT]))
    else $error("fraction enable not taken");
endmodule
`default_nettype wire

/* File: verification/pbd_bank_tb_top.sv */
// Purpose: self-checking bench for the loop B control bank
// Assumes: registers reached through the byte port of pbd_bank
// Notes:   random stimulus from a fixed seed plus corner cases
`timescale 1ns/1ps
`default_nettype none
`include "pbd_cfg.svh"
module pbd_bank_tb_top
  import pbd_pkg::*;
;
  logic           mclk;
  logic           reset;
  logic           clk_en;
  logic           device_soft_reset;
  logic           single_loop_soft_reset;
  logic [15:0]    reg_addr;
  logic           reg_wr;
  logic           reg_rd;
  logic [7:0]     reg_wdata;
  logic [7:0]     reg_rdata;
  logic [1:0]     select_pins;
  logic           zero_delay_mode;
  logic [1:0]     zero_delay_input_choice;
  logic           loss_of_lock_flag;
  logic           bandwidth_apply_strobe;
  logic           divider_apply_strobe;
  pbd_divider_t   divider_working;
  pbd_div_mode_t  divider_mode;
  pbd_loop_ctrl_t loop_ctrl;
  int             n_mismatch;
  int             compares;
  logic [12:0]    rate_t [8] = '{13'h094, 13'h0DE, 13'h0FD, 13'h076,
                                 13'h04A, 13'h1FA, 13'h3F4, 13'hFD0};
  logic [12:0]    mult_t [8] = '{13'h004, 13'h010, 13'h040, 13'h100,
                                 13'h400, 13'h1000, 13'h001, 13'h002};

  pbd_bank i_dut (
    .mclk                    (mclk),
    .reset                   (reset),
    .clk_en                  (clk_en),
    .device_soft_reset       (device_soft_reset),
    .single_loop_soft_reset  (single_loop_soft_reset),
    .reg_addr                (reg_addr),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_wdata               (reg_wdata),
    .reg_rdata               (reg_rdata),
    .select_pins             (select_pins),
    .zero_delay_mode         (zero_delay_mode),
    .zero_delay_input_choice (zero_delay_input_choice),
    .loss_of_lock_flag       (loss_of_lock_flag),
    .bandwidth_apply_strobe  (bandwidth_apply_strobe),
    .divider_apply_strobe    (divider_apply_strobe),
    .divider_working         (divider_working),
    .divider_mode            (divider_mode),
    .loop_ctrl               (loop_ctrl)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_out(input string what, input logic [87:0] exp, input logic [87:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    compares++;
    if (reg_rdata !== exp) begin
      n_mismatch++;
      $display("[ERR] register %h expected %h seen %h", a, exp, reg_rdata);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle pulse check, called at the taking edge
  task automatic strobe_chk(input logic bw, input logic dv);
    #1;
    chk_out("strobes", 88'({bw, dv}), 88'({bandwidth_apply_strobe, divider_apply_strobe}));
    @(posedge mclk);
    #1;
    chk_out("strobes low", 88'h0, 88'({bandwidth_apply_strobe, divider_apply_strobe}));
  endtask

  task automatic wait_fast(input logic e);
    int n;
    n = 0;
    while (loop_ctrl.fast_bw_sel !== e && n < 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk_out("fast bandwidth", 88'(e), 88'(loop_ctrl.fast_bw_sel));
    if (loop_ctrl.fast_bw_sel !== e) begin
      finish_test();
    end
  endtask

  function automatic logic [2:0] exp_sel(logic [7:0] v, logic [1:0] p, logic z, logic [1:0] zc);
    if (!v[0]) begin
      return {1'b1, p};
    end
    if (z) begin
      return {1'b1, zc};
    end
    return {~v[3], v[2:1]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [55:0]  num;
    logic [31:0]  den;
    logic [31:0]  r;
    logic [7:0]   v;
    logic [2:0]   sel_exp;
    logic [7:0]   fr [3];
    logic [1:0]   fl_ctrl [6];
    logic         fl_lol [6];
    logic         fl_exp [6];
    n_mismatch = 0;
    compares = 0;
    fr = '{8'h3B, 8'h2B, 8'hFB};
    fl_ctrl = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
    fl_lol = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    fl_exp = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    reset = 1'b1;
    clk_en = 1'b1;
    device_soft_reset = 1'b0;
    single_loop_soft_reset = 1'b0;
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    select_pins = 2'h0;
    zero_delay_mode = 1'b0;
    zero_delay_input_choice = 2'h0;
    loss_of_lock_flag = 1'b0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    void'($urandom(32'h50E7));
    // reset values and unmapped place
    wr(16'h0522, 8'hFF);
    chk_reg(16'h0522, 8'h00);
    chk_reg(`PBD_ADDR_FRAC_CTRL, 8'h00);
    chk_reg(`PBD_ADDR_INSEL_CTRL, 8'h00);
    chk_reg(`PBD_ADDR_FAST_CTRL, 8'h00);
    chk_reg(`PBD_ADDR_HOLD_CTRL, 8'h01);
    chk_out("working reset", 88'h0, divider_working);
    // divider staging and transfer
    for (int k = 0; k < 4; k++) begin
      num = 56'({$urandom(), $urandom()});
      den = $urandom();
      if (k == 0) begin
        num = 56'hFF_FFFF_FFFF_FFFF;
        den = 32'h0000_0001;
      end
      r = 32'(k);
      for (int b = 0; b < 7; b++) wr(`PBD_ADDR_NUM_BASE + 16'(b), num[8*b +: 8]);
      for (int b = 0; b < 4; b++) wr(`PBD_ADDR_DEN_BASE + 16'(b), den[8*b +: 8]);
      for (int b = 0; b < 7; b++) chk_reg(`PBD_ADDR_NUM_BASE + 16'(b), num[8*b +: 8]);
      for (int b = 0; b < 4; b++) chk_reg(`PBD_ADDR_DEN_BASE + 16'(b), den[8*b +: 8]);
      wr(`PBD_ADDR_DIV_APPLY, 8'h00);
      strobe_chk(1'b0, 1'b0);
      wr(`PBD_ADDR_DIV_APPLY, 8'h01);
      strobe_chk(1'b0, 1'b1);
      chk_out("working divider", {num, den}, divider_working);
      chk_reg(`PBD_ADDR_DIV_APPLY, 8'h00);
    end
    // bandwidth strobe
    wr(`PBD_ADDR_BW_APPLY, 8'h00);
    strobe_chk(1'b0, 1'b0);
    wr(`PBD_ADDR_BW_APPLY, 8'h01);
    strobe_chk(1'b1, 1'b0);
    chk_reg(`PBD_ADDR_BW_APPLY, 8'h00);
    // soft resets
    num[7:0] = ~num[7:0];
    wr(`PBD_ADDR_NUM_BASE, num[7:0]);
    @(posedge mclk);
    single_loop_soft_reset <= 1'b1;
    @(posedge mclk);
    single_loop_soft_reset <= 1'b0;
    strobe_chk(1'b0, 1'b0);
    @(posedge mclk);
    device_soft_reset <= 1'b1;
    @(posedge mclk);
    device_soft_reset <= 1'b0;
    strobe_chk(1'b1, 1'b1);
    chk_out("working after soft reset", {num, den}, divider_working);
    // fractional control
    for (int k = 0; k < 3; k++) begin
      wr(`PBD_ADDR_FRAC_CTRL, fr[k]);
      #1;
      chk_out("divider mode", 88'({fr[k][4], fr[k][3:0], 4'h5}),
              88'(divider_mode));
      chk_reg(`PBD_ADDR_FRAC_CTRL, fr[k] & 8'h3F);
    end
    // input choice
    for (int k = 0; k < 24; k++) begin
      r = $urandom();
      v = 8'($urandom());
      if (k < 8) begin
        v[3:1] = 3'(k);
        v[0] = 1'b1;
      end
      @(posedge mclk);
      select_pins <= r[1:0];
      zero_delay_mode <= r[2] & (k > 7);
      zero_delay_input_choice <= r[4:3];
      wr(`PBD_ADDR_INSEL_CTRL, v);
      #1;
      sel_exp = exp_sel(v, r[1:0], r[2] & (k > 7), r[4:3]);
      chk_out("input choice", 88'(sel_exp),
              88'({loop_ctrl.input_valid, loop_ctrl.active_input}));
      chk_reg(`PBD_ADDR_INSEL_CTRL, v & 8'h0F);
    end
    // fast settle
    for (int k = 0; k < 6; k++) begin
      @(posedge mclk);
      loss_of_lock_flag <= fl_lol[k];
      wr(`PBD_ADDR_FAST_CTRL, {6'h00, fl_ctrl[k]});
      wait_fast(fl_exp[k]);
    end
    // holdover exit and ramp decode
    for (int rc = 0; rc < 8; rc++) begin
      for (int sc = 0; sc < 8; sc++) begin
        r = $urandom();
        v = {3'(rc), r[1], 1'b1, 2'b00, r[0]};
        wr(`PBD_ADDR_FAST_CTRL, {3'b000, 3'(sc), 2'b00});
        wr(`PBD_ADDR_HOLD_CTRL, v);
        #1;
        chk_out("hold ctrl",
                88'({r[0], r[1], 1'b1, rate_t[rc], mult_t[sc]}),
                88'({loop_ctrl.hold_allow, loop_ctrl.exit_normal_bw, loop_ctrl.ramp_bypass,
                     loop_ctrl.base_rate_cps, loop_ctrl.step_mult_q}));
      end
      chk_reg(`PBD_ADDR_HOLD_CTRL, v & 8'hF9);
    end
    // clock enable low freezes writes
    @(posedge mclk);
    clk_en <= 1'b0;
    wr(`PBD_ADDR_HOLD_CTRL, 8'h00);
    @(posedge mclk);
    clk_en <= 1'b1;
    chk_reg(`PBD_ADDR_HOLD_CTRL, v & 8'hF9);
    finish_test();
  end
endmodule
`default_nettype wire
